//--- core/eecc_top.sv
// eeprom command controller with axi4-lite register and array access
`timescale 1ns/1ps
`default_nettype none
`include "eecc_consts.svh"
module eecc_top #(
  parameter int ARRAY_WORDS = 1024,
  parameter logic [15:0] PROG_TICKS = `EECC_PROG_TICKS,
  parameter logic [15:0] ERASE_TICKS = `EECC_ERASE_TICKS,
  parameter logic [15:0] MASS_TICKS = `EECC_MASS_TICKS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [12:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [12:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power modes and special mode, same clock domain
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic special_mode,
  // status to the system
  output logic irq,
  output logic high_voltage_on
);
  localparam int AW = $clog2(ARRAY_WORDS);

  // delivered erased so verify sees defined data
  logic [15:0] mem [ARRAY_WORDS] = '{default: `EECC_ERASED_WORD};
  logic [12:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held, w_held;
  logic divider_loaded_flag, prescale_by_eight;
  logic [5:0] divider_value;
  logic buffers_empty_irq_en, all_done_irq_en;
  logic protect_disable_bit, protect_open_bit;
  logic [10:0] protect_bound;
  logic buffers_empty_flag, all_done_flag, blank_flag;
  logic access_error_flag, protect_violation_flag;
  eecc_pkg::eecc_seq_e seq;
  eecc_pkg::eecc_exec_e ex;
  logic [AW-1:0] buf_addr, act_addr, ptr, ptr_end;
  logic [15:0] buf_data, act_data;
  logic [7:0] buf_cmd, act_cmd;
  logic buf_valid, stop_q, blank_acc;
  logic [15:0] ticks_left;
  logic [2:0] pre_cnt;
  logic [5:0] div_cnt;
  logic tick;
  // decoded write events
  logic wr_fire, wr_div, wr_cfg, wr_stat, wr_cmd, wr_arr, wr_ok;
  logic arr_aligned, arr_hi;
  logic [10:0] arr_idx;
  logic cmd_valid, prot_hit, seq_err, seq_protect_violation_flag, launch, fetch, done_evt;
  logic stop_enter, stop_exit;
  eecc_pkg::eecc_seq_e next_seq;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [15:0] mem_wdata;

  // axi write channels: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 13'h0000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EECC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `EECC_RESP_OKAY : `EECC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // address decode of the held write
  always_comb begin
    arr_hi = w_strb[2];
    arr_idx = {aw_addr[11:2], arr_hi};
    arr_aligned = (w_strb == 4'h3) || (w_strb == 4'hC);
    wr_div = 1'b0;
    wr_cfg = 1'b0;
    wr_stat = 1'b0;
    wr_cmd = 1'b0;
    wr_arr = 1'b0;
    wr_ok = 1'b1;
    if (aw_addr[`EECC_ARRAY_BASE_BIT]) begin
      if ({1'b0, aw_addr[11:0]} < 13'(ARRAY_WORDS * 2)) begin
        wr_arr = wr_fire;
      end else begin
        wr_ok = 1'b0;
      end
    end else if (aw_addr == `EECC_OFS_DIVIDER) begin
      wr_div = wr_fire;
    end else if (aw_addr == `EECC_OFS_CONFIG) begin
      wr_cfg = wr_fire;
    end else if (aw_addr == `EECC_OFS_STATUS) begin
      wr_stat = wr_fire;
    end else if (aw_addr == `EECC_OFS_COMMAND) begin
      wr_cmd = wr_fire;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // command sequence checking
  always_comb begin
    cmd_valid = (w_data[7:0] == `EECC_CMD_VERIFY) ||
      (w_data[7:0] == `EECC_CMD_PROGRAM) ||
      (w_data[7:0] == `EECC_CMD_SECTOR) ||
      (w_data[7:0] == `EECC_CMD_MASS) ||
      (w_data[7:0] == `EECC_CMD_MODIFY);
    if (w_data[7:0] == `EECC_CMD_MASS) begin
      prot_hit = !(protect_disable_bit && protect_open_bit);
    end else if (w_data[7:0] == `EECC_CMD_VERIFY) begin
      prot_hit = 1'b0;
    end else begin
      prot_hit = !protect_disable_bit &&
        ({{(11 - AW){1'b0}}, buf_addr} >= protect_bound);
    end
    next_seq = seq;
    seq_err = 1'b0;
    seq_protect_violation_flag = 1'b0;
    launch = 1'b0;
    if (wr_arr) begin
      if (!divider_loaded_flag || !arr_aligned ||
          !buffers_empty_flag || seq != eecc_pkg::SEQ_IDLE) begin
        seq_err = 1'b1;
        next_seq = eecc_pkg::SEQ_IDLE;
      end else begin
        next_seq = eecc_pkg::SEQ_WORD;
      end
    end else if (wr_cmd) begin
      if (seq == eecc_pkg::SEQ_WORD) begin
        if (!cmd_valid) begin
          seq_err = !special_mode;
          next_seq = special_mode ? seq : eecc_pkg::SEQ_IDLE;
        end else if (prot_hit) begin
          seq_protect_violation_flag = 1'b1;
          next_seq = eecc_pkg::SEQ_IDLE;
        end else begin
          next_seq = eecc_pkg::SEQ_CMD;
        end
      end else if (seq == eecc_pkg::SEQ_CMD) begin
        seq_err = 1'b1;
        next_seq = eecc_pkg::SEQ_IDLE;
      end
    end else if ((wr_div || wr_cfg) && seq != eecc_pkg::SEQ_IDLE) begin
      seq_err = 1'b1;
      next_seq = eecc_pkg::SEQ_IDLE;
    end else if (wr_stat && seq == eecc_pkg::SEQ_WORD) begin
      seq_err = 1'b1;
      next_seq = eecc_pkg::SEQ_IDLE;
    end else if (wr_stat && seq == eecc_pkg::SEQ_CMD) begin
      next_seq = eecc_pkg::SEQ_IDLE;
      if (!w_data[`EECC_ST_BE_BIT]) begin
        seq_err = 1'b1;
      end else begin
        // a launch racing stop exit is dropped with the queued command
        launch = !access_error_flag && !protect_violation_flag &&
          !stop_exit;
      end
    end
  end

  assign stop_enter = stop_mode && !stop_q;
  assign stop_exit = !stop_mode && stop_q;
  // wait mode does not hold the queue back, only stop does
  assign fetch = (ex == eecc_pkg::EX_IDLE) && buf_valid && !stop_mode;

  // divider and configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divider_loaded_flag <= 1'b0;
      prescale_by_eight <= 1'b0;
      divider_value <= 6'h00;
      buffers_empty_irq_en <= 1'b0;
      all_done_irq_en <= 1'b0;
      protect_disable_bit <= `EECC_RST_PDIS;
      protect_open_bit <= `EECC_RST_POPEN;
      protect_bound <= `EECC_RST_BOUND;
    end else begin
      if (wr_div && seq == eecc_pkg::SEQ_IDLE) begin
        divider_loaded_flag <= 1'b1;
        prescale_by_eight <= w_data[`EECC_DIV_PRESCALE_BIT];
        divider_value <= w_data[5:0];
      end
      if (wr_cfg && seq == eecc_pkg::SEQ_IDLE) begin
        buffers_empty_irq_en <= w_data[`EECC_CFG_BE_IE_BIT];
        all_done_irq_en <= w_data[`EECC_CFG_DONE_IE_BIT];
        protect_disable_bit <= w_data[`EECC_CFG_PDIS_BIT];
        protect_open_bit <= w_data[`EECC_CFG_POPEN_BIT];
        protect_bound <= w_data[`EECC_CFG_BOUND_MSB:`EECC_CFG_BOUND_LSB];
      end
    end
  end

  // timing clock: prescaler then divide by divider_value plus one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt <= 3'h0;
      div_cnt <= 6'h00;
    end else if (divider_loaded_flag) begin
      pre_cnt <= prescale_by_eight ? pre_cnt + 3'h1 : 3'h0;
      if (!prescale_by_eight || pre_cnt == 3'h7) begin
        div_cnt <= (div_cnt >= divider_value) ? 6'h00 : div_cnt + 6'h01;
      end
    end
  end
  assign tick = divider_loaded_flag &&
    (!prescale_by_eight || pre_cnt == 3'h7) && (div_cnt >= divider_value);

  // sequence state and command buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq <= eecc_pkg::SEQ_IDLE;
      buf_valid <= 1'b0;
      buf_addr <= '0;
      buf_data <= 16'h0000;
      buf_cmd <= 8'h00;
    end else begin
      seq <= next_seq;
      if (wr_arr && next_seq == eecc_pkg::SEQ_WORD) begin
        buf_addr <= arr_idx[AW-1:0];
        buf_data <= arr_hi ? w_data[31:16] : w_data[15:0];
      end
      if (wr_cmd && next_seq == eecc_pkg::SEQ_CMD) begin
        buf_cmd <= w_data[7:0];
      end
      if (stop_exit) begin
        buf_valid <= 1'b0;
      end else if (launch) begin
        buf_valid <= 1'b1;
      end else if (fetch) begin
        buf_valid <= 1'b0;
      end
    end
  end

  // status flags; an error set wins over a write-one clear in the same cycle, but a launch clear wins over a done or blank set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffers_empty_flag <= 1'b1;
      all_done_flag <= 1'b1;
      blank_flag <= 1'b0;
      access_error_flag <= 1'b0;
      protect_violation_flag <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_mode;
      if (launch) begin
        buffers_empty_flag <= 1'b0;
      end else if (fetch || stop_exit) begin
        buffers_empty_flag <= 1'b1;
      end
      if (launch) begin
        all_done_flag <= 1'b0;
      end else if (stop_enter && ex != eecc_pkg::EX_IDLE) begin
        all_done_flag <= 1'b1;
      end else if (done_evt && !buf_valid) begin
        all_done_flag <= 1'b1;
      end
      if (launch) begin
        blank_flag <= 1'b0;
      end else if (done_evt && ex == eecc_pkg::EX_VERIFY) begin
        blank_flag <= blank_acc && (mem[ptr] == `EECC_ERASED_WORD);
      end
      if (seq_err || (stop_enter && ex != eecc_pkg::EX_IDLE)) begin
        access_error_flag <= 1'b1;
      end else if (wr_stat && w_data[`EECC_ST_ACCESS_ERROR_FLAG_BIT]) begin
        access_error_flag <= 1'b0;
      end
      if (seq_protect_violation_flag) begin
        protect_violation_flag <= 1'b1;
      end else if (wr_stat && w_data[`EECC_ST_PROTECT_VIOLATION_FLAG_BIT]) begin
        protect_violation_flag <= 1'b0;
      end
    end
  end

  // command execution; reset drops straight back to idle
  always_comb begin
    done_evt = 1'b0;
    mem_we = 1'b0;
    mem_waddr = ptr;
    mem_wdata = `EECC_ERASED_WORD;
    case (ex)
      eecc_pkg::EX_ERASE_SWEEP: begin
        mem_we = !stop_enter;
        done_evt = (ptr == ptr_end) && (act_cmd != `EECC_CMD_MODIFY);
      end
      eecc_pkg::EX_PROG_WAIT: begin
        mem_we = tick && (ticks_left <= 16'd1) && !stop_enter;
        mem_waddr = act_addr;
        mem_wdata = act_data;
        done_evt = mem_we;
      end
      eecc_pkg::EX_VERIFY: begin
        done_evt = (ptr == AW'(ARRAY_WORDS - 1)) && !stop_enter;
      end
      default: begin
        done_evt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ex <= eecc_pkg::EX_IDLE;
      act_addr <= '0;
      act_data <= 16'h0000;
      act_cmd <= 8'h00;
      ptr <= '0;
      ptr_end <= '0;
      ticks_left <= 16'h0000;
      blank_acc <= 1'b1;
    end else if (stop_enter) begin
      ex <= eecc_pkg::EX_IDLE;
    end else begin
      case (ex)
        eecc_pkg::EX_IDLE: begin
          if (fetch) begin
            act_addr <= buf_addr;
            act_data <= buf_data;
            act_cmd <= buf_cmd;
            blank_acc <= 1'b1;
            if (buf_cmd == `EECC_CMD_VERIFY) begin
              ptr <= '0;
              ex <= eecc_pkg::EX_VERIFY;
            end else if (buf_cmd == `EECC_CMD_PROGRAM) begin
              ticks_left <= PROG_TICKS;
              ex <= eecc_pkg::EX_PROG_WAIT;
            end else if (buf_cmd == `EECC_CMD_MASS) begin
              ticks_left <= MASS_TICKS;
              ptr <= '0;
              ptr_end <= AW'(ARRAY_WORDS - 1);
              ex <= eecc_pkg::EX_ERASE_WAIT;
            end else begin
              // sector of two words: the low address bit is ignored
              ticks_left <= ERASE_TICKS;
              ptr <= {buf_addr[AW-1:1], 1'b0};
              ptr_end <= {buf_addr[AW-1:1], 1'b1};
              ex <= eecc_pkg::EX_ERASE_WAIT;
            end
          end
        end
        eecc_pkg::EX_ERASE_WAIT: begin
          if (tick) begin
            ticks_left <= ticks_left - 16'd1;
            if (ticks_left <= 16'd1) begin
              ex <= eecc_pkg::EX_ERASE_SWEEP;
            end
          end
        end
        eecc_pkg::EX_ERASE_SWEEP: begin
          if (ptr != ptr_end) begin
            ptr <= ptr + AW'(1);
          end else if (act_cmd == `EECC_CMD_MODIFY) begin
            ticks_left <= PROG_TICKS;
            ex <= eecc_pkg::EX_PROG_WAIT;
          end else begin
            ex <= eecc_pkg::EX_IDLE;
          end
        end
        eecc_pkg::EX_PROG_WAIT: begin
          if (tick) begin
            ticks_left <= ticks_left - 16'd1;
            if (ticks_left <= 16'd1) begin
              ex <= eecc_pkg::EX_IDLE;
            end
          end
        end
        eecc_pkg::EX_VERIFY: begin
          blank_acc <= blank_acc && (mem[ptr] == `EECC_ERASED_WORD);
          ptr <= ptr + AW'(1);
          if (done_evt) begin
            ex <= eecc_pkg::EX_IDLE;
          end
        end
        default: begin
          ex <= eecc_pkg::EX_IDLE;
        end
      endcase
    end
  end

  // array storage
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // axi read channel: one cycle latency; reads have no side effects
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `EECC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `EECC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (s_axi_araddr[`EECC_ARRAY_BASE_BIT]) begin
        if ({1'b0, s_axi_araddr[11:0]} >= 13'(ARRAY_WORDS * 2)) begin
          s_axi_rresp <= `EECC_RESP_SLVERR;
        end else if (all_done_flag) begin
          // while an algorithm runs the array data is not valid
          s_axi_rdata <= {mem[{s_axi_araddr[AW:2], 1'b1}],
                          mem[{s_axi_araddr[AW:2], 1'b0}]};
        end
      end else if (s_axi_araddr == `EECC_OFS_DIVIDER) begin
        s_axi_rdata[7:0] <= {divider_loaded_flag, prescale_by_eight,
                             divider_value};
      end else if (s_axi_araddr == `EECC_OFS_CONFIG) begin
        s_axi_rdata[`EECC_CFG_BE_IE_BIT] <= buffers_empty_irq_en;
        s_axi_rdata[`EECC_CFG_DONE_IE_BIT] <= all_done_irq_en;
        s_axi_rdata[`EECC_CFG_PDIS_BIT] <= protect_disable_bit;
        s_axi_rdata[`EECC_CFG_POPEN_BIT] <= protect_open_bit;
        s_axi_rdata[`EECC_CFG_BOUND_MSB:`EECC_CFG_BOUND_LSB] <= protect_bound;
      end else if (s_axi_araddr == `EECC_OFS_STATUS) begin
        s_axi_rdata[`EECC_ST_BE_BIT] <= buffers_empty_flag;
        s_axi_rdata[`EECC_ST_DONE_BIT] <= all_done_flag;
        s_axi_rdata[`EECC_ST_PROTECT_VIOLATION_FLAG_BIT] <= protect_violation_flag;
        s_axi_rdata[`EECC_ST_ACCESS_ERROR_FLAG_BIT] <= access_error_flag;
        s_axi_rdata[`EECC_ST_BLANK_BIT] <= blank_flag;
      end else if (s_axi_araddr == `EECC_OFS_COMMAND) begin
        s_axi_rdata[7:0] <= buf_cmd;
      end else begin
        s_axi_rresp <= `EECC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // interrupt also serves as wake-up from wait mode
  assign irq = (buffers_empty_flag && buffers_empty_irq_en) ||
    (all_done_flag && all_done_irq_en);
  assign high_voltage_on = !stop_mode && (ex == eecc_pkg::EX_ERASE_WAIT ||
    ex == eecc_pkg::EX_ERASE_SWEEP || ex == eecc_pkg::EX_PROG_WAIT);

  logic unused_ok;
  assign unused_ok = wait_mode;
endmodule
`default_nettype wire

//--- core/eecc_consts.svh
// offsets, field positions, reset values, command codes and timing counts
`ifndef EECC_CONSTS_SVH
`define EECC_CONSTS_SVH
`define EECC_OFS_DIVIDER 13'h0000
`define EECC_OFS_CONFIG 13'h0004
`define EECC_OFS_STATUS 13'h0008
`define EECC_OFS_COMMAND 13'h000C
`define EECC_ARRAY_BASE_BIT 12
`define EECC_DIV_LOADED_BIT 7
`define EECC_DIV_PRESCALE_BIT 6
`define EECC_CFG_BE_IE_BIT 7
`define EECC_CFG_DONE_IE_BIT 6
`define EECC_CFG_PDIS_BIT 1
`define EECC_CFG_POPEN_BIT 0
`define EECC_CFG_BOUND_LSB 16
`define EECC_CFG_BOUND_MSB 26
`define EECC_ST_BE_BIT 7
`define EECC_ST_DONE_BIT 6
`define EECC_ST_PROTECT_VIOLATION_FLAG_BIT 5
`define EECC_ST_ACCESS_ERROR_FLAG_BIT 4
`define EECC_ST_BLANK_BIT 2
`define EECC_RST_PDIS 1'b1
`define EECC_RST_POPEN 1'b0
`define EECC_RST_BOUND 11'h7FF
`define EECC_CMD_VERIFY 8'h05
`define EECC_CMD_PROGRAM 8'h20
`define EECC_CMD_SECTOR 8'h40
`define EECC_CMD_MASS 8'h41
`define EECC_CMD_MODIFY 8'h60
`define EECC_PROG_TICKS 16'd30
`define EECC_ERASE_TICKS 16'd200
`define EECC_MASS_TICKS 16'd400
`define EECC_ERASED_WORD 16'hFFFF
`define EECC_RESP_OKAY 2'b00
`define EECC_RESP_SLVERR 2'b10
`endif

//--- core/eecc_pkg.sv
// types of the eeprom command controller
package eecc_pkg;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WORD, SEQ_CMD} eecc_seq_e;
  typedef enum logic [2:0] {
    EX_IDLE, EX_ERASE_WAIT, EX_ERASE_SWEEP, EX_PROG_WAIT, EX_VERIFY
  } eecc_exec_e;
endpackage

//--- sim/eecc_assertions.sv
// port checker for the eeprom command controller
`timescale 1ns/1ps
`default_nettype none
module eecc_assertions (
  // clock and reset
  input wire logic aclk, aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [12:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  // modes and status
  input wire logic stop_mode, irq, high_voltage_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_reg_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr < 13'h0010;
  endsequence
  property p_wr_answer;
    s_wr_taken |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no write answer");
  property p_reg_read;
    s_reg_read |=> s_axi_rvalid && s_axi_rresp == 2'h0;
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("bad reg read");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write not refused");
  property p_r_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("read not refused");
  // high voltage must drop in the same cycle stop is seen
  property p_stop_hv;
    stop_mode |-> !high_voltage_on;
  endproperty
  a_stop_hv: assert property (p_stop_hv) else $error("voltage in stop");
  property p_reset_quiet;
    $rose(aresetn) |-> !irq && !high_voltage_on && !s_axi_bvalid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("busy reset");
endmodule
bind eecc_top eecc_assertions eecc_assertions_i (.*);
`default_nettype wire

//--- sim/eecc_axi_master.sv
// axi4-lite master standing in for the cpu
`timescale 1ns/1ps
`default_nettype none
module eecc_axi_master (
  // clock
  input wire logic aclk,
  // write side
  output logic [12:0] s_axi_awaddr,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready,
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  // read side
  output logic [12:0] s_axi_araddr,
  output logic s_axi_arvalid, s_axi_rready,
  input wire logic s_axi_arready, s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
  end
  // aw and w offered together, each dropped once its own ready is seen
  task automatic wr(input logic [12:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad = ad || s_axi_awready;
      wd = wd || s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- sim/eecc_tb_top.sv
// self-checking bench for the eeprom command controller
`timescale 1ns/1ps
`default_nettype none
`include "eecc_consts.svh"
module eecc_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, stop_mode = 1'b0, wait_mode = 1'b0;
  logic special_mode = 1'b0;
  logic [12:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, dv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, irq, high_voltage_on;
  int fails = 0, tests_run = 0, seed = 32'h7134, i, k;
  logic [15:0] mem [64];
  always #20 aclk = ~aclk;
  // short counts keep the mass erase run within a few hundred cycles
  eecc_top #(.PROG_TICKS(16'h3), .ERASE_TICKS(16'h4), .MASS_TICKS(16'h4),
    .ARRAY_WORDS(64)) eecc_top_i (.*);
  eecc_axi_master eecc_axi_master_i (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF);
    eecc_axi_master_i.wr(a, d, s, r);
  endtask
  task automatic rd(input logic [12:0] a);
    eecc_axi_master_i.rd(a, v, r);
  endtask
  task automatic st(input logic [31:0] e);
    rd(`EECC_OFS_STATUS);
    chk(v, e);
  endtask
  function automatic logic [12:0] aa(input int n);
    return 13'h1000 + 13'(n / 2 * 4);
  endfunction
  task automatic seq(input int n, input logic [15:0] d, input logic [7:0] c);
    wr(aa(n), {d, d}, n[0] ? 4'hC : 4'h3);
    wr(`EECC_OFS_COMMAND, {24'h0, c});
    wr(`EECC_OFS_STATUS, 32'h80);
  endtask
  task automatic done_wait;
    do rd(`EECC_OFS_STATUS); while (v[6] !== 1'b1);
  endtask
  task automatic wchk(input int n);
    rd(aa(n));
    chk(v, {mem[n | 1], mem[n & ~1]});
  endtask
  task give_verdict;
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    for (k = 0; k < 64; k++) mem[k] = 16'hFFFF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`EECC_OFS_DIVIDER);
    chk(v, 32'h0);
    st(32'hC0);
    wr(aa(0), 32'h1234, 4'h3);
    st(32'hD0);
    wr(`EECC_OFS_STATUS, 32'h0);
    st(32'hD0);
    wr(`EECC_OFS_STATUS, 32'h10);
    st(32'hC0);
    dv = $random(seed) & 32'hF;
    wr(`EECC_OFS_DIVIDER, dv);
    rd(`EECC_OFS_DIVIDER);
    chk(v, dv | 32'h80);
    rd(13'h0100);
    chk({30'h0, r}, {30'h0, `EECC_RESP_SLVERR});
    seq($random(seed) & 63, 16'h0, `EECC_CMD_VERIFY);
    done_wait;
    st(32'hC4);
    i = $random(seed) & 62;
    mem[i] = 16'($random(seed));
    mem[i + 1] = 16'($random(seed));
    wait_mode <= 1'b1;
    seq(i, mem[i], `EECC_CMD_PROGRAM);
    seq(i + 1, mem[i + 1], `EECC_CMD_PROGRAM);
    done_wait;
    wait_mode <= 1'b0;
    st(32'hC0);
    wchk(i);
    mem[i] = 16'($random(seed));
    mem[i + 1] = 16'hFFFF;
    seq(i, mem[i], `EECC_CMD_MODIFY);
    done_wait;
    wchk(i);
    seq(0, 16'h0, `EECC_CMD_VERIFY);
    done_wait;
    st(32'hC0);
    seq(i + 1, 16'h0, `EECC_CMD_SECTOR);
    mem[i] = 16'hFFFF;
    done_wait;
    wchk(i);
    // codes above 0x7F are never valid, so any random one will do
    seq(i, 16'h0, 8'($random(seed)) | 8'h80);
    st(32'hD0);
    seq(i, 16'h0, `EECC_CMD_PROGRAM);
    wchk(i);
    wr(`EECC_OFS_STATUS, 32'h10);
    wr(aa(i), 32'h0, 4'h3);
    wr(`EECC_OFS_STATUS, 32'h0);
    st(32'hD0);
    wr(`EECC_OFS_STATUS, 32'h10);
    wr(aa(i), 32'h0, 4'h3);
    wr(`EECC_OFS_DIVIDER, 32'h3F);
    st(32'hD0);
    rd(`EECC_OFS_DIVIDER);
    chk(v, dv | 32'h80);
    wr(`EECC_OFS_STATUS, 32'h10);
    special_mode <= 1'b1;
    wr(aa(i), 32'h0, 4'h3);
    wr(`EECC_OFS_COMMAND, 32'hFF);
    st(32'hC0);
    wr(`EECC_OFS_STATUS, 32'h0);
    special_mode <= 1'b0;
    st(32'hD0);
    wr(`EECC_OFS_STATUS, 32'h10);
    seq(i, 16'h0, `EECC_CMD_MASS);
    st(32'hE0);
    wr(`EECC_OFS_STATUS, 32'h20);
    wr(`EECC_OFS_CONFIG, 32'h07FF0083);
    chk({31'h0, irq}, 32'h1);
    mem[i] = 16'($random(seed));
    seq(i, mem[i], `EECC_CMD_PROGRAM);
    done_wait;
    wchk(i);
    seq(0, 16'h0, `EECC_CMD_MASS);
    mem[i] = 16'hFFFF;
    done_wait;
    wchk(i);
    seq(i, 16'h0, `EECC_CMD_MASS);
    st(32'h80);
    chk({31'h0, high_voltage_on}, 32'h1);
    stop_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    stop_mode <= 1'b0;
    st(32'hD0);
    chk({31'h0, high_voltage_on}, 32'h0);
    wr(`EECC_OFS_STATUS, 32'h10);
    seq(0, 16'h0, `EECC_CMD_MASS);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk({31'h0, irq}, 32'h0);
    st(32'hC0);
    rd(`EECC_OFS_DIVIDER);
    chk(v, 32'h0);
    give_verdict;
  end
  // watchdog: generous against the few thousand cycles the tests need
  initial begin
    #2000000;
    fails++;
    give_verdict;
  end
endmodule
`default_nettype wire
